// *** logic/redriver_cfg_pkg.sv ***
// constants, types and states for the redriver configuration-select block
//
// Behaviour
// - source-mode field 0h TMDS, 3h alternate source
// - source-mode register at 31h, reset 00h
// - mode strap F selects serial-bus configuration
// - mode strap 0, R or H selects pin-strap
// - snooping always active in pin-strap operation
// - swap strap low means no lane swap
// - linear strap 0 limited, otherwise linear
// - coupling strap low gives DC-coupled transmitter
// - two eq straps pick sixteen eq settings
// - floating pre-emphasis strap gives 0 dB
// - floating swing strap gives default swing
package redriver_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SRC_MODE_OFFSET = 8'h31;
  localparam logic [7:0] SRC_MODE_RESET = 8'h00;
  localparam logic [3:0] SRC_MODE_TMDS = 4'h0;
  localparam logic [3:0] SRC_MODE_ALT = 4'h3;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // serial bus
  // ----------------------------------------------------------------
  // base device address is arbitrary; low two bits come from the shared strap
  localparam logic [4:0] DEV_ADDR_BASE = 5'h0B;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // strap levels and decoded codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_RES = 2'h1,
    LVL_FLOAT = 2'h2,
    LVL_HIGH = 2'h3
  } strap_level_t;

  localparam logic [2:0] PREEMPH_DEFAULT = 3'h0;
  localparam logic [2:0] SWING_DEFAULT = 3'h3;

  typedef struct packed {
    strap_level_t mode;
    strap_level_t linear_sel;
    strap_level_t output_coupling;
    strap_level_t eq_upper;
    strap_level_t addr_eq_lower;
    strap_level_t tx_preemph;
    strap_level_t tx_swing;
  } straps_t;

  typedef struct packed {
    logic serial_cfg;
    logic fixed_eq;
    logic snoop_en;
    logic lane_swap;
    logic linear_en;
    logic dc_coupled;
    logic [3:0] eq_sel;
    logic [2:0] preemph;
    logic [2:0] swing;
    logic alt_source_en;
  } cfg_t;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WR,
    ST_ACK,
    ST_RD,
    ST_MACK
  } bus_state_t;

endpackage

// *** logic/redriver_config_select.sv ***
// configuration select: strap decode, serial register slave, source-mode register
`timescale 1ns/10ps
module redriver_config_select (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // enable pin and straps
  input wire logic i_en,
  input wire redriver_cfg_pkg::straps_t i_straps,
  // serial configuration bus (open drain data)
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // decoded configuration
  output redriver_cfg_pkg::cfg_t o_cfg,
  output logic [7:0] o_source_mode_select
);

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic en_q;
  logic strap_load;
  redriver_cfg_pkg::straps_t straps;
  logic data_swap_strap;

  // straps are caught on the enable rise, which the board holds off until
  // the rails are settled, so the resistor levels are valid by then
  assign strap_load = i_en & ~en_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= i_en;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      straps <= '0;
      data_swap_strap <= 1'b0;
    end else if (strap_load) begin
      straps <= i_straps;
      data_swap_strap <= i_sda;
    end
  end

  // ----------------------------------------------------------------
  // serial bus slave
  // ----------------------------------------------------------------
  redriver_cfg_pkg::bus_state_t state;
  redriver_cfg_pkg::bus_state_t after_ack;
  logic serial_cfg;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic mack_ok;
  logic [6:0] dev_addr;
  logic [7:0] source_mode_select;
  logic [7:0] rd_data;
  logic wr_en;

  assign serial_cfg = en_q && (straps.mode == redriver_cfg_pkg::LVL_FLOAT);
  assign dev_addr = {redriver_cfg_pkg::DEV_ADDR_BASE, straps.addr_eq_lower};
  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  assign bus_start = scl_q & i_scl & sda_q & ~i_sda;
  assign bus_stop = scl_q & i_scl & ~sda_q & i_sda;
  assign rd_data = (ptr == redriver_cfg_pkg::SRC_MODE_OFFSET) ? source_mode_select
                                                             : redriver_cfg_pkg::UNMAPPED_READ;
  assign wr_en = (state == redriver_cfg_pkg::ST_WR) && scl_fall
                 && (bit_cnt == redriver_cfg_pkg::BITS_PER_BYTE);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= redriver_cfg_pkg::ST_IDLE;
      after_ack <= redriver_cfg_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      mack_ok <= 1'b0;
    end else if (!serial_cfg || bus_stop) begin
      state <= redriver_cfg_pkg::ST_IDLE;
    end else if (bus_start) begin
      state <= redriver_cfg_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        redriver_cfg_pkg::ST_ADDR,
        redriver_cfg_pkg::ST_PTR,
        redriver_cfg_pkg::ST_WR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], i_sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == redriver_cfg_pkg::BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            if (state == redriver_cfg_pkg::ST_ADDR) begin
              if (shift[7:1] == dev_addr) begin
                state <= redriver_cfg_pkg::ST_ACK;
                after_ack <= shift[0] ? redriver_cfg_pkg::ST_RD : redriver_cfg_pkg::ST_PTR;
              end else begin
                state <= redriver_cfg_pkg::ST_IDLE;
              end
            end else if (state == redriver_cfg_pkg::ST_PTR) begin
              ptr <= shift;
              state <= redriver_cfg_pkg::ST_ACK;
              after_ack <= redriver_cfg_pkg::ST_WR;
            end else begin
              ptr <= ptr + 8'h01;
              state <= redriver_cfg_pkg::ST_ACK;
              after_ack <= redriver_cfg_pkg::ST_WR;
            end
          end
        end
        redriver_cfg_pkg::ST_ACK: begin
          if (scl_fall) begin
            state <= after_ack;
            tx <= rd_data;
          end
        end
        redriver_cfg_pkg::ST_RD: begin
          if (scl_fall) begin
            tx <= {tx[6:0], 1'b0};
            if (bit_cnt == redriver_cfg_pkg::BITS_PER_BYTE - 4'h1) begin
              bit_cnt <= 4'h0;
              ptr <= ptr + 8'h01;
              state <= redriver_cfg_pkg::ST_MACK;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        redriver_cfg_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_ok <= ~i_sda;
          end else if (scl_fall) begin
            // a not-acknowledge ends the read; the master then sends stop
            state <= mack_ok ? redriver_cfg_pkg::ST_RD : redriver_cfg_pkg::ST_IDLE;
            tx <= rd_data;
          end
        end
        default: begin
          state <= redriver_cfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever pulls low, the pull-up makes the high level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sda_oe <= 1'b0;
    end else begin
      o_sda_oe <= serial_cfg && !bus_stop && !bus_start
                  && ((state == redriver_cfg_pkg::ST_ACK && !scl_fall)
                      || (state == redriver_cfg_pkg::ST_RD && !tx[7] && !scl_fall)
                      || (state == redriver_cfg_pkg::ST_ACK && scl_fall
                          && after_ack == redriver_cfg_pkg::ST_RD && !rd_data[7])
                      || (state == redriver_cfg_pkg::ST_RD && scl_fall
                          && bit_cnt != redriver_cfg_pkg::BITS_PER_BYTE - 4'h1 && !tx[6])
                      || (state == redriver_cfg_pkg::ST_MACK && scl_fall && mack_ok
                          && !rd_data[7])
                      || (wr_en || (scl_fall && bit_cnt == redriver_cfg_pkg::BITS_PER_BYTE
                          && (state == redriver_cfg_pkg::ST_PTR
                              || (state == redriver_cfg_pkg::ST_ADDR
                                  && shift[7:1] == dev_addr)))));
    end
  end

  assign o_sda_out = 1'b0;

  // ----------------------------------------------------------------
  // source-mode register
  // ----------------------------------------------------------------
  // software is expected to set linear operation alongside the alternate mode;
  // the device does not force it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      source_mode_select <= redriver_cfg_pkg::SRC_MODE_RESET;
    end else if (wr_en && ptr == redriver_cfg_pkg::SRC_MODE_OFFSET) begin
      source_mode_select <= shift;
    end
  end

  assign o_source_mode_select = source_mode_select;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  redriver_cfg_pkg::cfg_t next_cfg;

  always_comb begin
    next_cfg = '0;
    next_cfg.serial_cfg = serial_cfg;
    next_cfg.fixed_eq = !serial_cfg && (straps.mode == redriver_cfg_pkg::LVL_LOW);
    next_cfg.snoop_en = !serial_cfg;
    next_cfg.lane_swap = !serial_cfg && data_swap_strap;
    next_cfg.linear_en = (straps.linear_sel != redriver_cfg_pkg::LVL_LOW);
    next_cfg.dc_coupled = (straps.output_coupling == redriver_cfg_pkg::LVL_LOW);
    next_cfg.eq_sel = {straps.eq_upper, straps.addr_eq_lower};
    case (straps.tx_preemph)
      redriver_cfg_pkg::LVL_LOW: next_cfg.preemph = 3'h1;
      redriver_cfg_pkg::LVL_RES: next_cfg.preemph = 3'h2;
      redriver_cfg_pkg::LVL_HIGH: next_cfg.preemph = 3'h4;
      default: next_cfg.preemph = redriver_cfg_pkg::PREEMPH_DEFAULT;
    endcase
    case (straps.tx_swing)
      redriver_cfg_pkg::LVL_LOW: next_cfg.swing = 3'h0;
      redriver_cfg_pkg::LVL_RES: next_cfg.swing = 3'h1;
      redriver_cfg_pkg::LVL_HIGH: next_cfg.swing = 3'h5;
      default: next_cfg.swing = redriver_cfg_pkg::SWING_DEFAULT;
    endcase
    // only a low nibble of 3h turns the alternate mode on; 0h and all other low-nibble codes leave it off
    next_cfg.alt_source_en =
        (source_mode_select[3:0] == redriver_cfg_pkg::SRC_MODE_ALT);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cfg <= '0;
    end else begin
      o_cfg <= next_cfg;
    end
  end

endmodule

// *** test/serial_host_model.sv ***
// serial configuration host model with open-drain data
`timescale 1ns/10ps
module serial_host_model (
  // clock
  input wire logic i_clk,
  // bus lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // each scl half lasts four clocks, twice the slave minimum
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wt;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic hold(input logic l);
    o_sda_low = l;
  endtask
  task automatic start;
    o_sda_low = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_low = 1'b1;
    wt();
    o_scl = 1'b0;
    wt();
  endtask
  task automatic stop;
    o_sda_low = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_low = 1'b0;
    wt();
  endtask
  // data only moves while scl is low, so no false start or stop
  task automatic hbit(input logic b, output logic r);
    o_sda_low = !b;
    wt();
    o_scl = 1'b1;
    wt();
    r = i_sda;
    wt();
    o_scl = 1'b0;
    wt();
  endtask
  task automatic xfer(input logic [7:0] d, input logic l, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      hbit(d[i], q[i]);
    end
    hbit(l, a);
  endtask
endmodule

// *** test/redriver_config_select_monitor.sv ***
// checker for strap decode and source-mode register
`timescale 1ns/10ps
module redriver_config_select_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // straps and results
  input wire logic i_en,
  input wire redriver_cfg_pkg::straps_t i_straps,
  input wire redriver_cfg_pkg::cfg_t o_cfg,
  input wire logic [7:0] o_source_mode_select
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reg_reset_a: assert property ($rose(i_nrst) |-> o_source_mode_select == 8'h00)
    else $error("source mode not cleared");
  alt_decode_a: assert property (o_cfg.alt_source_en ==
    (($past(o_source_mode_select) & 8'h0F) == 8'h03)) else $error("alt decode wrong");
  // the guard skips the edge that still shows the reset value
  snoop_on_a: assert property ($past(i_nrst) && !o_cfg.serial_cfg |-> o_cfg.snoop_en)
    else $error("snoop off in strap mode");
  serial_sel_a: assert property ($rose(i_en) |-> ##3
    o_cfg.serial_cfg == (i_straps.mode == redriver_cfg_pkg::LVL_FLOAT)) else $error("mode");
  fixed_eq_a: assert property ($rose(i_en) |-> ##3
    o_cfg.fixed_eq == (i_straps.mode == redriver_cfg_pkg::LVL_LOW)) else $error("fixed eq");
  linear_sel_a: assert property ($rose(i_en) |-> ##3
    o_cfg.linear_en == (i_straps.linear_sel != redriver_cfg_pkg::LVL_LOW)) else $error("lin");
  dc_couple_a: assert property ($rose(i_en) ##3
    i_straps.output_coupling == redriver_cfg_pkg::LVL_LOW |-> o_cfg.dc_coupled) else $error("dc");
  eq_select_a: assert property ($rose(i_en) |-> ##3
    o_cfg.eq_sel == {i_straps.eq_upper, i_straps.addr_eq_lower}) else $error("eq select");
  preemph_def_a: assert property ($rose(i_en) ##3
    i_straps.tx_preemph == redriver_cfg_pkg::LVL_FLOAT |-> o_cfg.preemph == 3'h0)
    else $error("pre");
  swing_def_a: assert property ($rose(i_en) ##3
    i_straps.tx_swing == redriver_cfg_pkg::LVL_FLOAT |-> o_cfg.swing == 3'h3) else $error("swing");
endmodule
bind redriver_config_select redriver_config_select_monitor mon_i (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_en(i_en), .i_straps(i_straps), .o_cfg(o_cfg),
  .o_source_mode_select(o_source_mode_select));

// *** test/test_redriver_config_select.sv ***
// testbench for the configuration-select block
`timescale 1ns/10ps
module test_redriver_config_select;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_en = 1'b0;
  redriver_cfg_pkg::straps_t i_straps = '0;
  logic scl;
  logic sda_low;
  logic o_sda_out;
  logic o_sda_oe;
  logic sda;
  logic [6:0] dev;
  redriver_cfg_pkg::cfg_t o_cfg;
  logic [7:0] o_source_mode_select;
  int fails = 0;
  int checks = 0;
  // pull-up on the data line
  assign sda = !(sda_low || (o_sda_oe && !o_sda_out));
  assign dev = {redriver_cfg_pkg::DEV_ADDR_BASE, i_straps.addr_eq_lower};
  always #50 i_clk = ~i_clk;
  redriver_config_select redriver_config_select_i (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_en(i_en), .i_straps(i_straps), .i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_cfg(o_cfg), .o_source_mode_select(o_source_mode_select));
  serial_host_model serial_host_model_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // straps only count on the enable rise, so enable drops first
  task automatic straps(input logic [13:0] s, input logic swap_low);
    @(negedge i_clk);
    i_en = 1'b0;
    i_straps = s;
    serial_host_model_i.hold(swap_low);
    repeat (2) @(negedge i_clk);
    i_en = 1'b1;
    repeat (6) @(negedge i_clk);
    serial_host_model_i.hold(1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] b [3];
    logic [7:0] q;
    logic a;
    b = '{{dev, 1'b0}, p, d};
    serial_host_model_i.start();
    for (int i = 0; i < 3; i++) begin
      serial_host_model_i.xfer(b[i], 1'b1, q, a);
      cmp1("ack", 1'b0, a);
    end
    serial_host_model_i.stop();
  endtask
  // two-byte read: the first byte is acknowledged so the pointer must step on
  task automatic rd(input logic [7:0] p, input logic [7:0] e, input logic [7:0] e_next);
    logic [7:0] q;
    logic a;
    serial_host_model_i.start();
    serial_host_model_i.xfer({dev, 1'b0}, 1'b1, q, a);
    serial_host_model_i.xfer(p, 1'b1, q, a);
    serial_host_model_i.start();
    serial_host_model_i.xfer({dev, 1'b1}, 1'b1, q, a);
    cmp1("read ack", 1'b0, a);
    serial_host_model_i.xfer(8'hFF, 1'b0, q, a);
    cmp8("read", e, q);
    serial_host_model_i.xfer(8'hFF, 1'b1, q, a);
    cmp8("read next", e_next, q);
    serial_host_model_i.stop();
  endtask
  // a frame the slave must leave unanswered
  task automatic probe(input logic [6:0] adr);
    logic [7:0] q;
    logic a;
    serial_host_model_i.start();
    serial_host_model_i.xfer({adr, 1'b0}, 1'b1, q, a);
    cmp1("nack", 1'b1, a);
    serial_host_model_i.stop();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_pin(input logic [13:0] s, input logic sw, input logic fix, input logic lin,
                       input logic [3:0] eq);
    straps(s, !sw);
    cmp1("serial", 1'b0, o_cfg.serial_cfg);
    cmp1("fixed_eq", fix, o_cfg.fixed_eq);
    cmp1("snoop", 1'b1, o_cfg.snoop_en);
    cmp1("swap", sw, o_cfg.lane_swap);
    cmp1("linear", lin, o_cfg.linear_en);
    cmp1("dc", 1'b1, o_cfg.dc_coupled);
    cmp8("eq", {4'h0, eq}, {4'h0, o_cfg.eq_sel});
    cmp8("preemph", 8'h00, {5'h00, o_cfg.preemph});
    cmp8("swing", {5'h00, redriver_cfg_pkg::SWING_DEFAULT}, {5'h00, o_cfg.swing});
    probe(dev);
    cmp8("reg", 8'h00, o_source_mode_select);
  endtask
  task automatic t_serial;
    straps(14'h2C0A, 1'b0);
    cmp1("serial", 1'b1, o_cfg.serial_cfg);
    probe(dev ^ 7'h01);
    wr(8'h31, 8'h03);
    cmp8("reg", 8'h03, o_source_mode_select);
    cmp1("alt", 1'b1, o_cfg.alt_source_en);
    rd(8'h31, 8'h03, 8'h00);
    wr(8'h31, 8'h05);
    cmp1("alt", 1'b0, o_cfg.alt_source_en);
    wr(8'h31, 8'hF0);
    cmp1("alt", 1'b0, o_cfg.alt_source_en);
    wr(8'h30, 8'hAA);
    rd(8'h30, 8'h00, 8'hF0);
    rd(8'h31, 8'hF0, 8'h00);
  endtask
  task automatic t_reset;
    @(negedge i_clk);
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    cmp8("reg", redriver_cfg_pkg::SRC_MODE_RESET, o_source_mode_select);
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    cmp8("reg", 8'h00, o_source_mode_select);
    t_pin(14'h009A, 1'b0, 1'b1, 1'b0, 4'h9);
    t_pin(14'h1CCA, 1'b1, 1'b0, 1'b1, 4'hC);
    t_serial();
    t_reset();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    $display("[ERR] run exp finished got timeout");
    end_sim();
  end
endmodule
